// File: core/acc_clkdiv.sv
// converter clock divider: tick once per 2^sel system clocks, plus a
// mid-period tick. assumes restart is a single-cycle pulse.
`timescale 1ns/1ps
module acc_clkdiv
#(
	parameter int SEL_W = 3,
	parameter int CNT_W = 7
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic restart,
	input wire logic [SEL_W-1:0] sel,
	output logic tick,
	output logic half
);
	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W:0] period;
	logic [CNT_W-1:0] last;
	logic [CNT_W-1:0] mid;

	// period is a power of two; half of one system clock rounds up to one
	assign period = (CNT_W+1)'(1) << sel; // RULE_20
	assign last = CNT_W'(period - (CNT_W+1)'(1));
	assign mid = (sel == '0) ? '0 : CNT_W'((period >> 1) - (CNT_W+1)'(1));
	assign tick = (cnt_ff == last);
	assign half = (cnt_ff == mid);
	assign nxt_cnt = (restart | tick) ? '0 : cnt_ff + CNT_W'(1);

	// free counter, realigned by restart
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt_ff <= '0;
		else
			cnt_ff <= nxt_cnt;
	end
endmodule // acc_clkdiv

// File: core/acc_ctrl.sv
// top of the converter control block: apb registers, start sequencing,
// phase timing, result latching, reference and input routing, pin override.
// assumes the analog core presents its 12-bit code on core_data at the end
// of the conversion phase.
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: software powers converter, waits before starting
// RULE_02: software powers converter down when idle
// RULE_03: reference from four-bit select field codes
// RULE_04: software enables reference amplifier when needed
// RULE_05: software sets reference pin share pattern
// RULE_06: analog-selected pin routes to converter only
// RULE_07: analog pin drops its pull-high resistor
// RULE_08: analog pin ignores its direction setting
// RULE_09: four sample clocks then twelve conversion clocks
// RULE_10: result latched half clock later; start alters
// RULE_11: software waits half clock before next start
// RULE_12: software sets internal select then channel
// RULE_13: software configures all, then pulses start
// RULE_14: software sets both enables before starting
// RULE_15: busy high during conversion, low at end
// RULE_16: interrupt when enabled and stack not full
// RULE_17: twelve-bit unsigned result, full scale fff
// RULE_18: start rise resets; start fall begins conversion
// RULE_19: format bit chooses high/low result split
// RULE_20: converter clock is system clock over 2^sel
// RULE_21: completion sets the converter interrupt flag
// RULE_22: unlisted reference codes act as supply
// RULE_23: internal source wins over external channel
module acc_ctrl
	import acc_pkg::*;
#(
	parameter int RES_W = 12,
	parameter int NPIN = 8
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ACC_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [RES_W-1:0] core_data,
	input wire logic stack_full,
	output logic conv_power_ff,
	output logic conv_reset_ff,
	output logic conv_sample_ff,
	output logic conv_convert_ff,
	output logic [3:0] ref_sel_ff,
	output logic ref_amp_en_ff,
	output logic bg_buf_en_ff,
	output logic [2:0] int_src_ff,
	output logic ext_connect_ff,
	output logic [2:0] ext_chan_ff,
	output logic [NPIN-1:0] pin_analog_ff,
	output logic [NPIN-1:0] pin_pullup_ff,
	output logic [NPIN-1:0] pin_dir_in_ff,
	output logic irq_ff
);
	logic [7:0] ctrl0_ff, ctrl1_ff, ctrl2_ff;
	logic [1:0] irq_en_ff;
	logic flag_ff, busy_ff, start_prev_ff;
	logic [NPIN-1:0] fsel_ff, pu_ff, dir_ff;
	logic [RES_W-1:0] pend_ff, result_ff;
	logic [3:0] tcnt_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff, pready_ff;
	acc_state_t state_ff;

	// bus decode
	wire setup = psel & ~penable;
	wire wr = psel & penable & pwrite;
	wire hit_c0 = paddr == ACC_OFF_CTRL0;
	wire hit_c1 = paddr == ACC_OFF_CTRL1;
	wire hit_c2 = paddr == ACC_OFF_CTRL2;
	wire hit_hi = paddr == ACC_OFF_RES_HI;
	wire hit_lo = paddr == ACC_OFF_RES_LO;
	wire hit_irq = paddr == ACC_OFF_IRQ;
	wire hit_pin = paddr == ACC_OFF_PIN;
	wire mapped = hit_c0 | hit_c1 | hit_c2 | hit_hi | hit_lo | hit_irq | hit_pin;

	// result split by format bit
	wire fmt = ctrl0_ff[ACC_B_FMT];
	wire [7:0] res_hi = fmt ? {4'h0, result_ff[11:8]} : result_ff[11:4]; // RULE_19
	wire [7:0] res_lo = fmt ? result_ff[7:0] : {4'h0, result_ff[3:0]}; // RULE_19

	// read mux; bit 3 of control 0 is unimplemented and reads zero
	wire [7:0] c0_rd = {ctrl0_ff[7], busy_ff, ctrl0_ff[5:4], 1'b0, ctrl0_ff[2:0]};
	wire [31:0] rd_mux =
		hit_c0 ? {24'h0, c0_rd} :
		hit_c1 ? {24'h0, ctrl1_ff[7:5], 2'h0, ctrl1_ff[2:0]} :
		hit_c2 ? {24'h0, ctrl2_ff[7:6], 2'h0, ctrl2_ff[3:0]} :
		hit_hi ? {24'h0, res_hi} :
		hit_lo ? {24'h0, res_lo} :
		hit_irq ? {29'h0, flag_ff, irq_en_ff} :
		hit_pin ? {8'h0, dir_ff, pu_ff, fsel_ff} : 32'h0;

	// start edge detection on the software start bit
	wire start_bit = ctrl0_ff[ACC_B_START];
	wire start_rise = start_bit & ~start_prev_ff; // RULE_18
	wire start_fall = ~start_bit & start_prev_ff; // RULE_18
	wire powered = ctrl0_ff[ACC_B_PWR];

	// converter clock from the divider
	wire tick, half;
	wire div_restart = start_fall | (state_ff == ACC_CONVERT & tick);
	acc_clkdiv #(.SEL_W(3), .CNT_W(7)) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.restart(div_restart),
		.sel(ctrl1_ff[2:0]),
		.tick(tick),
		.half(half)
	);

	// phase sequencing
	wire samp_end = state_ff == ACC_SAMPLE & tick & tcnt_ff == ACC_SAMPLE_CLKS - 4'h1;
	wire conv_end = state_ff == ACC_CONVERT & tick & tcnt_ff == ACC_CONV_CLKS - 4'h1;
	wire latch_now = state_ff == ACC_HOLD & half;
	acc_state_t nxt_state;
	assign nxt_state =
		(start_rise | ~powered) ? ACC_IDLE :
		(start_fall) ? ACC_SAMPLE :
		samp_end ? ACC_CONVERT : // RULE_09
		conv_end ? ACC_HOLD : // RULE_09
		latch_now ? ACC_IDLE : state_ff;
	wire [3:0] nxt_tcnt = (start_fall | samp_end) ? 4'h0 : (tick ? tcnt_ff + 4'h1 : tcnt_ff);
	wire nxt_busy = (start_rise | ~powered | conv_end) ? 1'b0 : (start_fall ? 1'b1 : busy_ff);

	// reference: unlisted codes fall back to the supply
	wire [3:0] rsel = ctrl2_ff[3:0];
	wire ref_ok = (rsel <= ACC_REF_EXT4) | (rsel >= ACC_REF_BG2 & rsel <= ACC_REF_BG4);
	wire [3:0] nxt_ref = ref_ok ? rsel : ACC_REF_SUPPLY; // RULE_03 RULE_22

	// input routing: code 4 behaves as the pin input
	wire [2:0] insel = ctrl1_ff[7:5];
	wire [2:0] nxt_int = (insel == ACC_IN_RSVD) ? ACC_IN_PIN : insel;

	// interrupt flag: completion set wins over a software clear
	wire flag_wr = wr & hit_irq;
	wire nxt_flag = conv_end | (flag_wr ? pwdata[ACC_B_FLAG] : flag_ff); // RULE_21

	// bus answer registered in setup, so the access phase never waits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_ff <= 32'h0;
			pslverr_ff <= 1'b0;
			pready_ff <= 1'b0;
		end
		else
		begin
			pready_ff <= 1'b1;
			if (setup)
			begin
				prdata_ff <= pwrite ? 32'h0 : rd_mux;
				pslverr_ff <= ~mapped;
			end
		end
	end
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	// software-written registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl0_ff <= ACC_RST_BYTE;
			ctrl1_ff <= ACC_RST_BYTE;
			ctrl2_ff <= ACC_RST_BYTE;
			irq_en_ff <= 2'h0;
			fsel_ff <= '0;
			pu_ff <= '0;
			dir_ff <= '0;
		end
		else if (wr)
		begin
			if (hit_c0)
				ctrl0_ff <= pwdata[7:0];
			if (hit_c1)
				ctrl1_ff <= pwdata[7:0];
			if (hit_c2)
				ctrl2_ff <= pwdata[7:0];
			if (hit_irq)
				irq_en_ff <= pwdata[1:0];
			if (hit_pin)
			begin
				fsel_ff <= pwdata[NPIN-1:0];
				pu_ff <= pwdata[ACC_B_PIN_PU +: NPIN];
				dir_ff <= pwdata[ACC_B_PIN_DIR +: NPIN];
			end
		end
	end

	// conversion state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= ACC_IDLE;
			tcnt_ff <= 4'h0;
			busy_ff <= 1'b0;
			flag_ff <= 1'b0;
			start_prev_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			tcnt_ff <= nxt_tcnt;
			busy_ff <= nxt_busy; // RULE_15
			flag_ff <= nxt_flag; // RULE_21
			start_prev_ff <= start_bit;
		end
	end

	// result pair: stored at the end, latched half a converter clock later;
	// a start rise inside that window clears the pair and cancels the latch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend_ff <= '0;
			result_ff <= '0;
		end
		else
		begin
			if (conv_end)
				pend_ff <= core_data; // RULE_17
			if (state_ff == ACC_HOLD & start_rise)
				result_ff <= '0; // RULE_10
			else if (latch_now)
				result_ff <= pend_ff; // RULE_10
		end
	end

	// outputs to the analog side and the pin pads
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			conv_power_ff <= 1'b0;
			conv_reset_ff <= 1'b0;
			conv_sample_ff <= 1'b0;
			conv_convert_ff <= 1'b0;
			ref_sel_ff <= ACC_REF_SUPPLY;
			ref_amp_en_ff <= 1'b0;
			bg_buf_en_ff <= 1'b0;
			int_src_ff <= ACC_IN_PIN;
			ext_connect_ff <= 1'b0;
			ext_chan_ff <= 3'h0;
			pin_analog_ff <= '0;
			pin_pullup_ff <= '0;
			pin_dir_in_ff <= '0;
			irq_ff <= 1'b0;
		end
		else
		begin
			conv_power_ff <= powered;
			conv_reset_ff <= start_rise; // RULE_18
			conv_sample_ff <= nxt_state == ACC_SAMPLE;
			conv_convert_ff <= nxt_state == ACC_CONVERT;
			ref_sel_ff <= nxt_ref;
			ref_amp_en_ff <= ctrl2_ff[ACC_B_AMP];
			bg_buf_en_ff <= ctrl2_ff[ACC_B_BGBUF];
			int_src_ff <= nxt_int;
			ext_connect_ff <= nxt_int == ACC_IN_PIN; // RULE_23
			ext_chan_ff <= ctrl0_ff[2:0];
			pin_analog_ff <= fsel_ff; // RULE_06
			pin_pullup_ff <= pu_ff & ~fsel_ff; // RULE_07
			pin_dir_in_ff <= dir_ff | fsel_ff; // RULE_08
			irq_ff <= nxt_flag & irq_en_ff[ACC_B_GIE] & irq_en_ff[ACC_B_CIE] & ~stack_full; // RULE_16
		end
	end

	a_sample_len: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
		samp_end && !start_rise && !start_fall && powered |=> state_ff == ACC_CONVERT && tcnt_ff == 4'h0)
		else $error("sample phase length wrong");
	a_conv_end: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
		conv_end && !start_rise && powered |=> !busy_ff && flag_ff && state_ff == ACC_HOLD)
		else $error("completion did not clear busy and set flag");
	a_start_busy: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
		start_fall && powered |=> busy_ff && state_ff == ACC_SAMPLE)
		else $error("start fall did not begin conversion");
	a_rise_reset: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
		start_rise |=> !busy_ff && conv_reset_ff && state_ff == ACC_IDLE)
		else $error("start rise did not reset converter");
	a_ref_fallback: assert property (@(posedge pclk) disable iff (!presetn) // RULE_22
		!ref_ok |=> ref_sel_ff == ACC_REF_SUPPLY)
		else $error("invalid reference code not forced to supply");
	a_pullup_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
		(pin_analog_ff & pin_pullup_ff) == '0)
		else $error("pull-high left on analog pin");
	a_dir_over: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
		(pin_analog_ff & ~pin_dir_in_ff) == '0)
		else $error("analog pin not forced to input");
	a_int_wins: assert property (@(posedge pclk) disable iff (!presetn) // RULE_23
		int_src_ff != ACC_IN_PIN |-> !ext_connect_ff)
		else $error("external channel connected with internal source");
	a_latch_res: assert property (@(posedge pclk) disable iff (!presetn) // RULE_10
		latch_now && !start_rise |=> result_ff == $past(pend_ff))
		else $error("result not latched from stored pair");
	a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE_16
		irq_ff |-> $past(irq_en_ff) == 2'h3 && !$past(stack_full))
		else $error("interrupt raised while gated");
endmodule // acc_ctrl

// File: core/acc_pkg.sv
// package for the converter control block: register map, field positions,
// reset values and phase lengths. assumes a 32-bit apb with byte addresses.
package acc_pkg;
	localparam int ACC_AW = 8;
	// register byte offsets
	localparam logic [7:0] ACC_OFF_CTRL0 = 8'h00;
	localparam logic [7:0] ACC_OFF_CTRL1 = 8'h04;
	localparam logic [7:0] ACC_OFF_CTRL2 = 8'h08;
	localparam logic [7:0] ACC_OFF_RES_HI = 8'h0c;
	localparam logic [7:0] ACC_OFF_RES_LO = 8'h10;
	localparam logic [7:0] ACC_OFF_IRQ = 8'h14;
	localparam logic [7:0] ACC_OFF_PIN = 8'h18;
	// control register 0 fields
	localparam int ACC_B_START = 7;
	localparam int ACC_B_BUSY = 6;
	localparam int ACC_B_PWR = 5;
	localparam int ACC_B_FMT = 4;
	// control register 1 fields
	localparam int ACC_B_INSEL = 5;
	// control register 2 fields
	localparam int ACC_B_AMP = 7;
	localparam int ACC_B_BGBUF = 6;
	// interrupt register fields
	localparam int ACC_B_GIE = 0;
	localparam int ACC_B_CIE = 1;
	localparam int ACC_B_FLAG = 2;
	// pin register fields: analog select, pull-high enable, direction
	localparam int ACC_B_PIN_PU = 8;
	localparam int ACC_B_PIN_DIR = 16;
	// reset values and reference and input select codes
	localparam logic [7:0] ACC_RST_BYTE = 8'h00;
	localparam logic [3:0] ACC_REF_SUPPLY = 4'h0;
	localparam logic [3:0] ACC_REF_EXT4 = 4'h4;
	localparam logic [3:0] ACC_REF_BG2 = 4'ha;
	localparam logic [3:0] ACC_REF_BG4 = 4'hc;
	localparam logic [2:0] ACC_IN_PIN = 3'h0;
	localparam logic [2:0] ACC_IN_RSVD = 3'h4;
	// phase lengths in converter clocks
	localparam logic [3:0] ACC_SAMPLE_CLKS = 4'h4;
	localparam logic [3:0] ACC_CONV_CLKS = 4'hc;
	typedef enum logic [1:0] {ACC_IDLE, ACC_SAMPLE, ACC_CONVERT, ACC_HOLD} acc_state_t;
endpackage

// File: sim/acc_core_model.sv
// analog core stand-in: holds the test level while sampling and offers it
// as the code while converting. assumes the control block's phase outputs.
`timescale 1ns/1ps
module acc_core_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic conv_power_ff,
	input wire logic conv_reset_ff,
	input wire logic conv_sample_ff,
	input wire logic conv_convert_ff,
	input wire logic [11:0] analog_level,
	output logic [11:0] core_data
);
	logic [11:0] held_ff;
	logic [11:0] noise_ff;
	// track the level while sampling; a reset scrambles the held code
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			held_ff <= 12'h000;
			noise_ff <= 12'h000;
		end
		else
		begin
			noise_ff <= noise_ff + 12'h5a7;
			if (conv_reset_ff)
				held_ff <= ~held_ff;
			else if (conv_sample_ff && conv_power_ff)
				held_ff <= analog_level;
		end
	end
	// junk that moves every cycle outside conversion, so a mistimed sample shows
	assign core_data = (conv_convert_ff && conv_power_ff) ? held_ff : noise_ff ^ ~held_ff;
endmodule // acc_core_model

// File: sim/tb_top.sv
// self-checking bench for the converter control block: apb tasks, routing,
// conversions at every divider setting, irq gating. assumes acc_core_model.
`timescale 1ns/1ps
module tb_top;
	import acc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic stack_full = 1'b0;
	logic [ACC_AW-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [11:0] level = 12'h000;
	logic [31:0] prdata, rd, v;
	logic [15:0] e16;
	logic pready, pslverr, slv, pwr_o, rst_o, smp_o, cnv_o, amp_o, bg_o, ext_o, irq_o;
	logic [11:0] core_data;
	logic [3:0] ref_o;
	logic [2:0] src_o, chan_o;
	logic [7:0] pa_o, pu_o, dir_o;
	int seed = 78252;
	int err_count = 0;
	int cmp_count = 0;
	int n_samp, n_conv, n_rst;
	always #2.5 pclk = ~pclk;
	acc_ctrl i_acc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_data(core_data), .stack_full(stack_full),
		.conv_power_ff(pwr_o), .conv_reset_ff(rst_o), .conv_sample_ff(smp_o),
		.conv_convert_ff(cnv_o), .ref_sel_ff(ref_o), .ref_amp_en_ff(amp_o),
		.bg_buf_en_ff(bg_o), .int_src_ff(src_o), .ext_connect_ff(ext_o), .ext_chan_ff(chan_o),
		.pin_analog_ff(pa_o), .pin_pullup_ff(pu_o), .pin_dir_in_ff(dir_o), .irq_ff(irq_o));
	acc_core_model i_acc_core_model (.pclk(pclk), .presetn(presetn), .conv_power_ff(pwr_o),
		.conv_reset_ff(rst_o), .conv_sample_ff(smp_o), .conv_convert_ff(cnv_o),
		.analog_level(level), .core_data(core_data));
	// phase lengths seen at the core side, in pclk cycles
	always @(posedge pclk)
	begin
		n_samp += int'(smp_o === 1'b1);
		n_conv += int'(cnv_o === 1'b1);
		n_rst += int'(rst_o === 1'b1);
	end
	function automatic logic [3:0] ref_exp(input logic [3:0] c);
		return (c <= 4'h4 || (c >= 4'ha && c <= 4'hc)) ? c : 4'h0;
	endfunction
	function automatic logic [2:0] src_exp(input logic [2:0] c);
		return (c == 3'h4) ? 3'h0 : c;
	endfunction
	// high byte then low byte for both result formats
	function automatic logic [15:0] res_exp(input logic [11:0] d, input logic f);
		return f ? {4'h0, d[11:8], d[7:0]} : {d[11:4], 4'h0, d[3:0]};
	endfunction
	task automatic test_done;
		begin
			$display("comparisons %0d mismatches %0d", cmp_count, err_count);
			if (err_count == 0 && cmp_count > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task automatic fail(input string m);
		begin
			err_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		begin
			cmp_count++;
			if (g !== e)
				fail($sformatf("got %h expected %h", g, e));
		end
	endtask
	// one apb transfer; an idle edge first so no signal is driven twice at once
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		begin
			n = 0;
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			@(posedge pclk);
			while (pready !== 1'b1 && n < 50)
			begin
				@(posedge pclk);
				n++;
			end
			if (n >= 50)
			begin
				fail("no ready");
				test_done;
			end
			rd = prdata;
			slv = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task automatic settle;
		begin
			repeat (2) @(posedge pclk);
			#1;
		end
	endtask
	// full start pulse, poll busy, then check timing and result split
	task automatic conv(input logic [2:0] s, input logic f, input logic [11:0] d);
		int k;
		begin
			k = 0;
			e16 = res_exp(d, f);
			@(posedge pclk);
			level <= d;
			apb(1'b1, ACC_OFF_CTRL1, {29'h0, s});
			apb(1'b1, ACC_OFF_IRQ, {29'h0, 1'b0, f, f});
			apb(1'b1, ACC_OFF_CTRL0, {24'h0, 3'b001, f, 4'h1});
			settle;
			n_samp = 0;
			n_conv = 0;
			n_rst = 0;
			apb(1'b1, ACC_OFF_CTRL0, {24'h0, 3'b101, f, 4'h1});
			apb(1'b1, ACC_OFF_CTRL0, {24'h0, 3'b001, f, 4'h1});
			apb(1'b0, ACC_OFF_CTRL0, 32'h0);
			chk({31'h0, rd[6]}, 32'h1);
			chk({31'h0, pwr_o}, 32'h1);
			while (rd[6] !== 1'b0 && k < 1000)
			begin
				apb(1'b0, ACC_OFF_CTRL0, 32'h0);
				k++;
			end
			if (k >= 1000)
			begin
				fail("busy stuck");
				test_done;
			end
			// wait beyond half a converter clock before reading
			repeat (1 << s) @(posedge pclk);
			settle;
			chk(n_rst, 1);
			chk(n_samp, 4 << s);
			chk(n_conv, 12 << s);
			apb(1'b0, ACC_OFF_RES_HI, 32'h0);
			chk(rd, {24'h0, e16[15:8]});
			apb(1'b0, ACC_OFF_RES_LO, 32'h0);
			chk(rd, {24'h0, e16[7:0]});
			chk({31'h0, irq_o}, {31'h0, f});
			apb(1'b0, ACC_OFF_IRQ, 32'h0);
			chk(rd, {29'h0, 1'b1, f, f});
			$display("test conversion sel %0d done", s);
		end
	endtask
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, a read-only write and the unmapped word
		apb(1'b1, ACC_OFF_RES_HI, 32'hff);
		for (int a = 0; a < 8; a++)
		begin
			apb(1'b0, 8'(a * 4), 32'h0);
			chk(rd, 32'h0);
			chk({31'h0, slv}, {31'h0, a == 7});
		end
		chk({31'h0, slv}, 32'h1);
		$display("test reset done");
		for (int c = 0; c < 16; c++)
		begin
			apb(1'b1, ACC_OFF_CTRL2, {24'h0, ref_exp(c[3:0]) != 4'h0, c[1], 2'b00, c[3:0]});
			settle;
			chk({28'h0, ref_o}, {28'h0, ref_exp(c[3:0])});
			chk({30'h0, amp_o, bg_o}, {30'h0, ref_exp(c[3:0]) != 4'h0, c[1]});
		end
		$display("test reference done");
		for (int c = 0; c < 8; c++)
		begin
			v = $random(seed);
			apb(1'b1, ACC_OFF_CTRL1, {24'h0, c[2:0], 5'h0});
			apb(1'b1, ACC_OFF_CTRL0, {29'h0, v[2:0]});
			settle;
			chk({28'h0, ext_o, src_o}, {28'h0, src_exp(c[2:0]) == 3'h0, src_exp(c[2:0])});
			chk({29'h0, chan_o}, {29'h0, v[2:0]});
		end
		$display("test input select done");
		for (int i = 0; i < 5; i++)
		begin
			v = (i == 0) ? 32'h00ffff : $random(seed);
			apb(1'b1, ACC_OFF_PIN, v);
			apb(1'b0, ACC_OFF_PIN, 32'h0);
			chk(rd, v & 32'hffffff);
			chk({8'h0, pa_o, pu_o, dir_o}, {8'h0, v[7:0], v[15:8] & ~v[7:0], v[23:16] | v[7:0]});
		end
		$display("test pins done");
		for (int s = 0; s < 8; s++)
		begin
			v = $random(seed);
			conv(s[2:0], s[0], (s == 0) ? 12'hfff : (s == 1) ? 12'h000 : v[11:0]);
		end
		// start pulse with power off must not convert
		n_samp = 0;
		apb(1'b1, ACC_OFF_CTRL0, 32'h80);
		apb(1'b1, ACC_OFF_CTRL0, 32'h00);
		settle;
		apb(1'b0, ACC_OFF_CTRL0, 32'h0);
		chk(rd, 32'h0);
		chk({n_samp[30:0], pwr_o}, 32'h0);
		$display("test power off done");
		apb(1'b1, ACC_OFF_IRQ, 32'h7);
		settle;
		chk({31'h0, irq_o}, 32'h1);
		@(posedge pclk);
		stack_full <= 1'b1;
		settle;
		chk({31'h0, irq_o}, 32'h0);
		@(posedge pclk);
		stack_full <= 1'b0;
		apb(1'b1, ACC_OFF_IRQ, 32'h3);
		settle;
		chk({31'h0, irq_o}, 32'h0);
		apb(1'b0, ACC_OFF_IRQ, 32'h0);
		chk(rd, 32'h3);
		$display("test irq done");
		test_done;
	end
endmodule // tb_top
